// *** design/pmr_data_table.sv ***
// hard-coded power data table indexed by the data select field
// assumes a combinational consumer that registers the result
`timescale 1ns/100ps
module pmr_data_table (
	// selection
	input  wire logic [3:0] sel,
	// reported entry
	output logic      [7:0] data,
	output logic      [1:0] scale
);
	// fixed value per selection, units of 0.01 W
	function automatic logic [7:0] pmr_data_of(input logic [3:0] s);
		logic [7:0] v;
		v = pmr_pkg::DATA_NONE;
		if (s == pmr_pkg::SEL_D0_CONS || s == pmr_pkg::SEL_D0_DISS) begin
			v = pmr_pkg::DATA_D0;
		end else if (s < pmr_pkg::SEL_COMMON) begin
			v = pmr_pkg::DATA_DX;
		end
		return v;
	endfunction

	assign data  = pmr_data_of(sel);
	assign scale = (sel <= pmr_pkg::SEL_COMMON) ? pmr_pkg::SCALE_ONE : pmr_pkg::SCALE_NONE;
endmodule

// *** design/pmr_pkg.sv ***
// power management register bank: shared constants, types and carrier structs
// assumes a single 125 MHz clock domain and a word-wide register access port
package pmr_pkg;

	// configuration space offsets
	localparam logic [7:0]  CFG_PMC_OFF       = 8'hdc;
	localparam logic [7:0]  CFG_CTLSTS_OFF    = 8'he0;
	// host control block offsets (memory and i/o space)
	localparam logic [7:0]  HCB_WAKE_OFF      = 8'h18;
	localparam logic [7:0]  HCB_GCTL_OFF      = 8'h1c;

	// capability word at the capability pointer
	localparam logic [7:0]  PMC_CAP_ID        = 8'h01;
	localparam logic [7:0]  PMC_NEXT_PTR      = 8'h00;
	localparam logic [15:0] PMC_VALUE         = 16'h7e21;

	// control/status word field positions
	localparam int          PS_LSB            = 0;
	localparam int          DYN_BIT           = 4;
	localparam int          EN_BIT            = 8;
	localparam int          SEL_LSB           = 9;
	localparam int          SCALE_LSB         = 13;
	localparam int          STS_BIT           = 15;
	localparam int          DATA_LSB          = 24;
	localparam logic [15:0] CTLSTS_RST        = 16'h0000;

	// wake indication byte: upper lane of word 18h
	localparam int          WAKE_LANE         = 3;
	localparam int          WAKE_IND_BIT      = 7;
	localparam logic [7:0]  WAKE_RST          = 8'h00;

	// general control byte: lane 0 of word 1ch
	localparam int          GCTL_DPD_BIT      = 0;
	localparam int          GCTL_CLKRUN_BIT   = 1;
	localparam logic [7:0]  GCTL_RST          = 8'h00;

	// power data table, units of 0.01 W
	localparam int          DATA_UNIT_MW      = 10;
	localparam int          DATA_MAX_MW       = 2550;
	localparam logic [7:0]  DATA_D0           = 8'h3c;
	localparam logic [7:0]  DATA_DX           = 8'h2a;
	localparam logic [7:0]  DATA_NONE         = 8'h00;
	localparam logic [3:0]  SEL_D0_CONS       = 4'h0;
	localparam logic [3:0]  SEL_D0_DISS       = 4'h4;
	localparam logic [3:0]  SEL_COMMON        = 4'h8;
	localparam logic [1:0]  SCALE_ONE         = 2'h1;
	localparam logic [1:0]  SCALE_NONE        = 2'h0;

	typedef enum logic [1:0] {
		PS_D0 = 2'h0,
		PS_D1 = 2'h1,
		PS_D2 = 2'h2,
		PS_D3 = 2'h3
	} pmr_pstate_type;

	typedef enum logic [1:0] {
		SPACE_CFG = 2'h0,
		SPACE_MEM = 2'h1,
		SPACE_IO  = 2'h2
	} pmr_space_type;

	typedef struct packed {
		logic          wr;
		logic          rd;
		pmr_space_type space;
		logic [7:0]    addr;
		logic [3:0]    be;
		logic [31:0]   wdata;
	} pmr_req_type;

endpackage

// *** design/pmr_regs.sv ***
// power management register bank of an ethernet pci controller
// assumes the pci bridge presents one access per cycle on the request carrier
// Function
// - wake event sets status bit 15 whatever the wake enable holds
// - writing one to bit 15 clears it, drops the wake pin, clears wake indication
// - with wake enabled, the wake pin follows the status bit
// - wake pin asserts only when enable bit 8 is set; enable resets to zero
// - power state bits 1:0 read back and take writes; 00..11 mean d0..d3
// - data select bits 12:9 choose the data and scale entry reported
// - data scale bits 14:13 read one for selections 0-8, zero for 9-15
// - data reads 60 for 0 and 4, 42 for 1-3, 5-7, zero otherwise
// - data register is 8-bit fixed, read only, set by selection alone
// - data values count in 0.01 W steps, range 0 to 2.55 W
// - dynamic data bit 4 always reads zero
// - reserved bits 7:5 and 3:2 read zero; host writes zeros
// - wake indication sits in the upper byte of word 18h, memory and i/o
// - general control byte at 1ch sets deep power-down and clock-run disable
`timescale 1ns/100ps
module pmr_regs (
	// clock and reset
	input  wire logic                 SYS_CLK,
	input  wire logic                 RST,
	// register access from the pci bridge
	input  wire pmr_pkg::pmr_req_type REG_REQ,
	output logic [31:0]               REG_RDATA,
	output logic                      REG_ACK,
	// wake event from the wake detection logic
	input  wire logic                 WAKE_EVENT,
	// open-drain wake pin, active low
	output logic                      PME_N_O,
	output logic                      PME_N_OE,
	// power control outputs
	output logic [1:0]                POWER_STATE,
	output logic                      DEEP_PWRDN,
	output logic                      CLKRUN_DIS
);

	// decode
	logic        is_cfg;
	logic        hit_pmc;
	logic        hit_ctlsts;
	logic        hit_wake;
	logic        hit_gctl;
	logic        wr_ctlsts_lo;
	logic        wr_ctlsts_hi;
	logic        wr_wake;
	logic        wr_gctl;
	logic        sts_clr;
	logic        ind_clr;
	logic        wake_pulse;

	// state
	logic        pme_sts_r;
	logic        pme_sts_nxt;
	logic        pme_en_r;
	logic        pme_en_nxt;
	logic [3:0]  sel_r;
	logic [3:0]  sel_nxt;
	logic [1:0]  ps_r;
	logic [1:0]  ps_nxt;
	logic [7:0]  wake_r;
	logic [7:0]  wake_nxt;
	logic [7:0]  gctl_r;
	logic [7:0]  gctl_nxt;

	// read path
	logic [7:0]  tbl_data;
	logic [1:0]  tbl_scale;
	logic [15:0] ctlsts_view;
	logic [31:0] rdata_nxt;

	// wake event crossing
	pmr_sync_rise u_wake_sync (
		.clk        (SYS_CLK),
		.rst        (RST),
		.level_in   (WAKE_EVENT),
		.rise_pulse (wake_pulse)
	);

	// fixed power data lookup
	pmr_data_table u_table (
		.sel   (sel_r),
		.data  (tbl_data),
		.scale (tbl_scale)
	);

	// address decode
	always_comb begin
		is_cfg    = (REG_REQ.space == pmr_pkg::SPACE_CFG);
		hit_pmc   = 1'b0;
		hit_ctlsts = 1'b0;
		hit_wake  = 1'b0;
		hit_gctl  = 1'b0;
		if (is_cfg && REG_REQ.addr == pmr_pkg::CFG_PMC_OFF) begin
			hit_pmc = 1'b1;
		end else if (is_cfg && REG_REQ.addr == pmr_pkg::CFG_CTLSTS_OFF) begin
			hit_ctlsts = 1'b1;
		end else if (!is_cfg && REG_REQ.addr == pmr_pkg::HCB_WAKE_OFF) begin
			hit_wake = 1'b1;
		end else if (!is_cfg && REG_REQ.addr == pmr_pkg::HCB_GCTL_OFF) begin
			hit_gctl = 1'b1;
		end
	end

	assign wr_ctlsts_lo = REG_REQ.wr & hit_ctlsts & REG_REQ.be[0];
	assign wr_ctlsts_hi = REG_REQ.wr & hit_ctlsts & REG_REQ.be[1];
	assign wr_wake      = REG_REQ.wr & hit_wake & REG_REQ.be[pmr_pkg::WAKE_LANE];
	assign wr_gctl      = REG_REQ.wr & hit_gctl & REG_REQ.be[0];
	assign sts_clr      = wr_ctlsts_hi & REG_REQ.wdata[pmr_pkg::STS_BIT];
	assign ind_clr      = sts_clr | (wr_wake & REG_REQ.wdata[pmr_pkg::WAKE_LANE * 8 + pmr_pkg::WAKE_IND_BIT]);

	// wake status: set wins over clear
	always_comb begin
		pme_sts_nxt = pme_sts_r;
		if (wake_pulse) begin
			pme_sts_nxt = 1'b1;
		end else if (sts_clr) begin
			pme_sts_nxt = 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			pme_sts_r <= pmr_pkg::CTLSTS_RST[pmr_pkg::STS_BIT];
		end else begin
			pme_sts_r <= pme_sts_nxt;
		end
	end

	// wake indication byte mirrors the status event
	always_comb begin
		wake_nxt = wake_r;
		if (wake_pulse) begin
			wake_nxt[pmr_pkg::WAKE_IND_BIT] = 1'b1;
		end else if (ind_clr) begin
			wake_nxt[pmr_pkg::WAKE_IND_BIT] = 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			wake_r <= pmr_pkg::WAKE_RST;
		end else begin
			wake_r <= wake_nxt;
		end
	end

	// wake enable
	always_comb begin
		pme_en_nxt = pme_en_r;
		if (wr_ctlsts_hi) begin
			pme_en_nxt = REG_REQ.wdata[pmr_pkg::EN_BIT];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			pme_en_r <= pmr_pkg::CTLSTS_RST[pmr_pkg::EN_BIT];
		end else begin
			pme_en_r <= pme_en_nxt;
		end
	end

	// data select
	always_comb begin
		sel_nxt = sel_r;
		if (wr_ctlsts_hi) begin
			sel_nxt = REG_REQ.wdata[pmr_pkg::SEL_LSB +: 4];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			sel_r <= pmr_pkg::CTLSTS_RST[pmr_pkg::SEL_LSB +: 4];
		end else begin
			sel_r <= sel_nxt;
		end
	end

	// power state
	always_comb begin
		ps_nxt = ps_r;
		if (wr_ctlsts_lo) begin
			ps_nxt = REG_REQ.wdata[pmr_pkg::PS_LSB +: 2];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			ps_r        <= pmr_pkg::PS_D0;
			POWER_STATE <= pmr_pkg::PS_D0;
		end else begin
			ps_r        <= ps_nxt;
			POWER_STATE <= ps_nxt;
		end
	end

	// general control byte
	always_comb begin
		gctl_nxt = gctl_r;
		if (wr_gctl) begin
			gctl_nxt[pmr_pkg::GCTL_DPD_BIT]    = REG_REQ.wdata[pmr_pkg::GCTL_DPD_BIT];
			gctl_nxt[pmr_pkg::GCTL_CLKRUN_BIT] = REG_REQ.wdata[pmr_pkg::GCTL_CLKRUN_BIT];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			gctl_r     <= pmr_pkg::GCTL_RST;
			DEEP_PWRDN <= 1'b0;
			CLKRUN_DIS <= 1'b0;
		end else begin
			gctl_r     <= gctl_nxt;
			DEEP_PWRDN <= gctl_nxt[pmr_pkg::GCTL_DPD_BIT];
			CLKRUN_DIS <= gctl_nxt[pmr_pkg::GCTL_CLKRUN_BIT];
		end
	end

	// wake pin: driven low while enabled and status set
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			PME_N_O  <= 1'b0;
			PME_N_OE <= 1'b0;
		end else begin
			PME_N_O  <= 1'b0;
			PME_N_OE <= pme_en_nxt & pme_sts_nxt;
		end
	end

	// control/status word as read
	always_comb begin
		ctlsts_view                              = 16'h0000;
		ctlsts_view[pmr_pkg::PS_LSB +: 2]        = ps_r;
		ctlsts_view[pmr_pkg::EN_BIT]             = pme_en_r;
		ctlsts_view[pmr_pkg::SEL_LSB +: 4]       = sel_r;
		ctlsts_view[pmr_pkg::SCALE_LSB +: 2]     = tbl_scale;
		ctlsts_view[pmr_pkg::STS_BIT]            = pme_sts_r;
	end

	// read data select
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (hit_pmc) begin
			rdata_nxt = {pmr_pkg::PMC_VALUE, pmr_pkg::PMC_NEXT_PTR, pmr_pkg::PMC_CAP_ID};
		end else if (hit_ctlsts) begin
			rdata_nxt = {tbl_data, 8'h00, ctlsts_view};
		end else if (hit_wake) begin
			rdata_nxt[pmr_pkg::WAKE_LANE * 8 +: 8] = wake_r;
		end else if (hit_gctl) begin
			rdata_nxt[7:0] = gctl_r;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			REG_RDATA <= 32'h0000_0000;
			REG_ACK   <= 1'b0;
		end else begin
			REG_ACK <= REG_REQ.rd | REG_REQ.wr;
			if (REG_REQ.rd) begin
				REG_RDATA <= rdata_nxt;
			end
		end
	end

	// checks
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (RST);

	sequence s_ctlsts_read;
		REG_REQ.rd && hit_ctlsts;
	endsequence

	sequence s_pin_clear;
		pme_sts_r && sts_clr && !wake_pulse;
	endsequence

	sts_set_a: assert property (wake_pulse |=> pme_sts_r && wake_r[pmr_pkg::WAKE_IND_BIT])
		else $error("wake event did not set status");

	sts_clear_a: assert property (sts_clr && !wake_pulse |=> !pme_sts_r && !wake_r[pmr_pkg::WAKE_IND_BIT])
		else $error("status clear did not clear both bits");

	pin_release_a: assert property (s_pin_clear |=> !PME_N_OE && !pme_sts_r)
		else $error("wake pin stayed asserted after clear");

	pin_follow_a: assert property (pme_en_r |-> PME_N_OE == pme_sts_r)
		else $error("wake pin does not follow status");

	pin_gate_a: assert property (PME_N_OE |-> pme_en_r && !PME_N_O)
		else $error("wake pin asserted while disabled");

	state_write_a: assert property (wr_ctlsts_lo |=> POWER_STATE == $past(REG_REQ.wdata[1:0]) && ps_r == POWER_STATE)
		else $error("power state write not taken");

	scale_read_a: assert property (s_ctlsts_read |=> REG_RDATA[14:13] == (($past(sel_r) <= 4'h8) ? 2'h1 : 2'h0))
		else $error("data scale wrong for selection");

	data_read_a: assert property (s_ctlsts_read |=>
		REG_RDATA[31:24] == ((($past(sel_r) == 4'h0) || ($past(sel_r) == 4'h4)) ? 8'h3c :
		(($past(sel_r) < 4'h8) ? 8'h2a : 8'h00)))
		else $error("data register value wrong");

	data_fixed_a: assert property ($stable(sel_r) |-> $stable(tbl_data))
		else $error("data register altered");

	rsvd_zero_a: assert property (s_ctlsts_read |=> REG_RDATA[7:2] == 6'h00 && REG_RDATA[23:16] == 8'h00)
		else $error("reserved or dynamic bits not zero");

	gctl_write_a: assert property (wr_gctl |=> DEEP_PWRDN == $past(REG_REQ.wdata[0]) && CLKRUN_DIS == $past(REG_REQ.wdata[1]))
		else $error("general control write not taken");

	reset_clear_a: assert property ($past(RST) |-> !pme_en_r && ps_r == 2'h0 && !PME_N_OE)
		else $error("control/status not cleared by reset");

endmodule

// *** design/pmr_sync_rise.sv ***
// two-flop synchroniser with rising-edge pulse
// assumes an asynchronous level input and a synchronous active-high reset
`timescale 1ns/100ps
module pmr_sync_rise (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// level in, pulse out
	input  wire logic level_in,
	output logic      rise_pulse
);
	logic meta_r;
	logic sync_r;
	logic last_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
		end else begin
			meta_r <= level_in;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	assign rise_pulse = sync_r & ~last_r;
endmodule

// *** dv/pmr_host_model.sv ***
// host bridge model issuing register accesses on the request carrier
// assumes the bank answers each access with a one-cycle acknowledge
`timescale 1ns/100ps
module pmr_host_model (
	// clock
	input  wire logic            clk,
	// request and answer
	output pmr_pkg::pmr_req_type req,
	input  wire logic [31:0]     rdata,
	input  wire logic            ack
);
	int n_lost;

	initial begin
		req = '0;
		n_lost = 0;
	end

	// one access: request for one edge, then wait a bounded time for the answer
	task automatic access(input logic wr, input pmr_pkg::pmr_space_type sp, input logic [7:0] addr,
			input logic [3:0] be, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		@(posedge clk);
		req.wr <= wr;
		req.rd <= ~wr;
		req.space <= sp;
		req.addr <= addr;
		req.be <= be;
		req.wdata <= wd;
		@(posedge clk);
		req.wr <= 1'b0;
		req.rd <= 1'b0;
		// released data lines do not keep their value
		req.wdata <= ~wd;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 8);
		if (ack !== 1'b1) begin
			n_lost++;
		end
		rd = rdata;
	endtask
endmodule

// *** dv/pmr_regs_tb.sv ***
// self-checking bench for the power management register bank
// assumes the host bridge model in its own file and a pull-up on the wake pin
`timescale 1ns/100ps
module pmr_regs_tb;
	localparam pmr_pkg::pmr_space_type CFG = pmr_pkg::SPACE_CFG;
	localparam pmr_pkg::pmr_space_type MEM = pmr_pkg::SPACE_MEM;
	localparam pmr_pkg::pmr_space_type IO  = pmr_pkg::SPACE_IO;
	logic                 sys_clk;
	logic                 rst;
	logic                 wake_event;
	pmr_pkg::pmr_req_type reg_req;
	logic [31:0]          reg_rdata;
	logic                 reg_ack;
	logic                 pme_n_o;
	logic                 pme_n_oe;
	logic [1:0]           power_state;
	logic                 deep_pwrdn;
	logic                 clkrun_dis;
	logic                 pme_n;
	logic [31:0]          rd;
	int                   n_mismatch;
	int                   compares;

	// open-drain wake pin with pull-up
	assign pme_n = pme_n_oe ? pme_n_o : 1'b1;

	pmr_regs i_pmr_regs (
		.SYS_CLK     (sys_clk),
		.RST         (rst),
		.REG_REQ     (reg_req),
		.REG_RDATA   (reg_rdata),
		.REG_ACK     (reg_ack),
		.WAKE_EVENT  (wake_event),
		.PME_N_O     (pme_n_o),
		.PME_N_OE    (pme_n_oe),
		.POWER_STATE (power_state),
		.DEEP_PWRDN  (deep_pwrdn),
		.CLKRUN_DIS  (clkrun_dis)
	);

	pmr_host_model i_pmr_host_model (
		.clk   (sys_clk),
		.req   (reg_req),
		.rdata (reg_rdata),
		.ack   (reg_ack)
	);

	always #4 sys_clk = ~sys_clk;

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic acc(input logic wr, input pmr_pkg::pmr_space_type sp, input logic [7:0] a,
			input logic [3:0] be, input logic [31:0] wd);
		i_pmr_host_model.access(wr, sp, a, be, wd, rd);
	endtask

	// expected control/status word with data byte on top
	function automatic logic [31:0] exp_word(input logic [3:0] sel, input logic en, input logic sts,
			input logic [1:0] ps);
		logic [7:0] d;
		d = (sel == 4'h0 || sel == 4'h4) ? 8'h3c : (sel < 4'h8) ? 8'h2a : 8'h00;
		return {d, 8'h00, sts, (sel <= 4'h8) ? 2'h1 : 2'h0, sel, en, 6'h00, ps};
	endfunction

	task automatic t_reset();
		acc(1'b0, CFG, 8'he0, 4'h0, 32'h0);
		check("word after reset", exp_word(4'h0, 1'b0, 1'b0, 2'h0), rd);
		acc(1'b0, CFG, 8'hdc, 4'h0, 32'h0);
		check("capability word", 32'h7e210001, rd);
		check("wake pin after reset", 32'h1, 32'(pme_n));
		check("power state after reset", 32'h0, 32'(power_state));
		$display("reset test done");
	endtask

	task automatic t_table();
		for (int s = 0; s < 16; s++) begin
			acc(1'b1, CFG, 8'he0, 4'hf, {8'hff, 11'h0, 4'(s), 9'h0});
			acc(1'b0, CFG, 8'he0, 4'h0, 32'h0);
			check("data and scale", exp_word(4'(s), 1'b0, 1'b0, 2'h0), rd);
		end
		$display("data table test done");
	endtask

	task automatic t_pstate();
		for (int p = 3; p >= 0; p--) begin
			acc(1'b1, CFG, 8'he0, 4'h3, {30'h0, 2'(p)});
			check("power state pins", 32'(p), 32'(power_state));
			acc(1'b0, CFG, 8'he0, 4'h0, 32'h0);
			check("power state word", exp_word(4'h0, 1'b0, 1'b0, 2'(p)), rd);
		end
		$display("power state test done");
	endtask

	task automatic t_wake();
		wake_event <= 1'b1;
		repeat (5) @(posedge sys_clk);
		check("wake pin disabled", 32'h1, 32'(pme_n));
		acc(1'b0, CFG, 8'he0, 4'h0, 32'h0);
		check("status set", exp_word(4'h0, 1'b0, 1'b1, 2'h0), rd);
		acc(1'b0, MEM, 8'h18, 4'h0, 32'h0);
		check("indication memory", 32'h80000000, rd);
		acc(1'b0, IO, 8'h18, 4'h0, 32'h0);
		check("indication io", 32'h80000000, rd);
		acc(1'b1, CFG, 8'he0, 4'h2, 32'h00000100);
		check("wake pin enabled", 32'h0, 32'(pme_n));
		acc(1'b1, CFG, 8'he0, 4'h2, 32'h00008100);
		check("wake pin cleared", 32'h1, 32'(pme_n));
		acc(1'b0, CFG, 8'he0, 4'h0, 32'h0);
		check("status cleared", exp_word(4'h0, 1'b1, 1'b0, 2'h0), rd);
		acc(1'b0, MEM, 8'h18, 4'h0, 32'h0);
		check("indication cleared", 32'h0, rd);
		wake_event <= 1'b0;
		repeat (4) @(posedge sys_clk);
		wake_event <= 1'b1;
		repeat (5) @(posedge sys_clk);
		acc(1'b1, MEM, 8'h18, 4'h8, 32'h80000000);
		check("wake pin held", 32'h0, 32'(pme_n));
		acc(1'b0, IO, 8'h18, 4'h0, 32'h0);
		check("indication only cleared", 32'h0, rd);
		acc(1'b0, CFG, 8'he0, 4'h0, 32'h0);
		check("status kept", exp_word(4'h0, 1'b1, 1'b1, 2'h0), rd);
		wake_event <= 1'b0;
		acc(1'b1, CFG, 8'he0, 4'h2, 32'h00008000);
		check("wake pin released", 32'h1, 32'(pme_n));
		$display("wake test done");
	endtask

	task automatic t_gctl();
		acc(1'b1, MEM, 8'h1c, 4'h1, 32'h3);
		check("control pins set", 32'h3, {30'h0, clkrun_dis, deep_pwrdn});
		acc(1'b0, IO, 8'h1c, 4'h0, 32'h0);
		check("control io read", 32'h3, rd);
		acc(1'b1, IO, 8'h1c, 4'h1, 32'h2);
		check("control pins io", 32'h2, {30'h0, clkrun_dis, deep_pwrdn});
		acc(1'b0, MEM, 8'h40, 4'h0, 32'h0);
		check("unmapped read", 32'h0, rd);
		$display("general control test done");
	endtask

	task automatic t_midreset();
		acc(1'b1, CFG, 8'he0, 4'h3, 32'h00000103);
		wake_event <= 1'b1;
		repeat (5) @(posedge sys_clk);
		check("wake pin before reset", 32'h0, 32'(pme_n));
		wake_event <= 1'b0;
		rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		acc(1'b0, CFG, 8'he0, 4'h0, 32'h0);
		check("word after second reset", exp_word(4'h0, 1'b0, 1'b0, 2'h0), rd);
		check("pins after second reset", 32'h1, {27'h0, clkrun_dis, deep_pwrdn, power_state, pme_n});
		$display("second reset test done");
	endtask

	task automatic finish_test();
		n_mismatch += i_pmr_host_model.n_lost;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		sys_clk = 1'b0;
		rst = 1'b1;
		wake_event = 1'b0;
		n_mismatch = 0;
		compares = 0;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset();
		t_table();
		t_pstate();
		t_wake();
		t_gctl();
		t_midreset();
		finish_test();
	end

	initial begin
		#200000;
		n_mismatch++;
		finish_test();
	end
endmodule
